// ---- common/power_unit_pkg.sv ----
/*
  Constants for the low-power mode controller: register offsets,
  field positions, reset values, timing counts and the mode type.
  Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package power_unit_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CPU_POWER = 8'h00;
  localparam logic [7:0] OFF_WAKE_CFG = 8'h04;
  localparam logic [7:0] OFF_UNIT_MODE = 8'h08;
  localparam logic [7:0] OFF_CONVERTER = 8'h0C;
  localparam logic [7:0] OFF_CONTROL = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_STOP = 1;
  localparam int BIT_IDLE = 0;
  localparam int BIT_SLEEP = 7;
  localparam int BIT_SUSPEND = 6;
  localparam int BIT_CLEAR = 5;
  localparam int BIT_RTC_OE = 7;
  localparam int BIT_WAKE_OE = 6;
  localparam int BIT_MON_OFF = 5;
  localparam int BIT_RAIL_FLOAT = 1;
  localparam int BIT_LCD_EN = 0;
  localparam int BIT_MODE_LO = 4;

  // ----------------------------------------------------------------
  // reset values and answers
  // ----------------------------------------------------------------
  localparam logic [5:0] GP_FLAGS_RST = 6'h00;
  localparam logic [3:0] WAKE_EN_RST = 4'h0;
  localparam logic [4:0] WAKE_FLAGS_RST = 5'h00;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int PIN_WAKE_US = 15;
  localparam int PIN_WAKE_CYC = PIN_WAKE_US * CLK_MHZ;
  localparam logic [1:0] FLAG_MASK_CYC = 2'h2;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_STOP = 2'b01,
    MODE_SUSPEND = 2'b10,
    MODE_SLEEP = 2'b11
  } power_mode_t;

endpackage

// ---- logic/rise_catch.sv ----
/*
  One-cycle pulse on each rising edge of a level.
  Assumes the level is synchronous to clk.
*/
`timescale 1ns/1ns
module rise_catch (
  input wire logic clk,
  input wire logic rstn,
  input wire logic level_in,
  output logic rise_pulse
);

  logic prev_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_in;
    end
  end

  assign rise_pulse = level_in & ~prev_reg;

endmodule

// ---- logic/low_power_mode_controller.sv ----
/*
  Low-power mode controller: stop, suspend and sleep entry and exit,
  wake-up flags, wake request pin and battery monitor control.
  Assumes synchronous inputs, one 10 MHz clock and an AXI4-Lite master.
*/
`timescale 1ns/1ns
module low_power_mode_controller
  import power_unit_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic osc_fail,
  input wire logic clock_alarm,
  input wire logic port_match,
  input wire logic comparator_out,
  input wire logic reset_pin_n,
  input wire logic clock_missing,
  input wire logic internal_reset,
  input wire logic two_cell_mode,
  output logic core_reset,
  output logic power_on_reset,
  output logic [15:0] restart_address,
  output logic cpu_halt,
  output logic precision_osc_en,
  output logic low_power_osc_en,
  output logic sys_clk_en,
  output logic core_regulator_en,
  output logic ram_on_battery,
  output logic rail_to_battery,
  output logic rail_floating,
  output logic gpio_hold,
  output logic port_match_live,
  output logic battery_monitor_en,
  output logic wake_request_out,
  output logic wake_request_oe_n
);

  // ----------------------------------------------------------------
  // state and configuration
  // ----------------------------------------------------------------
  power_mode_t mode_reg, mode_next;
  logic [5:0] gp_flags_reg;
  logic [3:0] wake_en_reg;
  logic [4:0] wake_flags_reg;
  logic [1:0] mask_cnt_reg;
  logic [7:0] pin_cnt_reg;
  logic pin_armed_reg;
  logic rtc_oe_reg, wake_oe_reg, mon_off_reg, rail_float_reg, lcd_en_reg;
  logic aw_rdy_reg, w_rdy_reg, b_vld_reg, ar_rdy_reg, r_vld_reg;
  logic [1:0] b_resp_reg, r_resp_reg;
  logic [31:0] r_data_reg;
  logic [4:0] evt;
  logic [4:0] flags_visible;
  logic wr_fire, wr_cpu, wr_wcfg, wr_mode, wr_conv, wr_ctrl, wr_hit;
  logic any_reset, pin_reset_fire, lcd_reset, wake_now, cmp_ok;
  logic enter_low;

  // ----------------------------------------------------------------
  // wake source edges
  // ----------------------------------------------------------------
  rise_catch u_osc_fail (
    .clk(clk),
    .rstn(rstn),
    .level_in(osc_fail),
    .rise_pulse(evt[3])
  );
  rise_catch u_alarm (
    .clk(clk),
    .rstn(rstn),
    .level_in(clock_alarm),
    .rise_pulse(evt[2])
  );
  rise_catch u_port_match (
    .clk(clk),
    .rstn(rstn),
    .level_in(port_match),
    .rise_pulse(evt[1])
  );
  rise_catch u_comparator (
    .clk(clk),
    .rstn(rstn),
    .level_in(comparator_out),
    .rise_pulse(evt[0])
  );
  rise_catch u_pin_fall (
    .clk(clk),
    .rstn(rstn),
    .level_in(~reset_pin_n),
    .rise_pulse(evt[4])
  );

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign wr_fire = aw_rdy_reg & awvalid & w_rdy_reg & wvalid;
  assign wr_hit = (awaddr == OFF_CPU_POWER) | (awaddr == OFF_WAKE_CFG) |
                  (awaddr == OFF_UNIT_MODE) | (awaddr == OFF_CONVERTER) |
                  (awaddr == OFF_CONTROL);
  assign wr_cpu = wr_fire & wstrb[0] & (awaddr == OFF_CPU_POWER);
  assign wr_wcfg = wr_fire & wstrb[0] & (awaddr == OFF_WAKE_CFG);
  assign wr_mode = wr_fire & wstrb[0] & (awaddr == OFF_UNIT_MODE);
  assign wr_conv = wr_fire & wstrb[0] & (awaddr == OFF_CONVERTER);
  assign wr_ctrl = wr_fire & wstrb[0] & (awaddr == OFF_CONTROL);

  // ----------------------------------------------------------------
  // reset sources and wake decision
  // ----------------------------------------------------------------
  // lost clock detector
  assign lcd_reset = lcd_en_reg & clock_missing;
  // pin reset after more than 15 us awake
  assign pin_reset_fire = pin_armed_reg & (pin_cnt_reg > 8'(PIN_WAKE_CYC));
  assign any_reset = internal_reset | lcd_reset | pin_reset_fire;
  // comparator wake from sleep needs two-cell mode
  assign cmp_ok = (mode_reg != MODE_SLEEP) | two_cell_mode;
  // enabled wake sources; pin edge always wakes
  assign wake_now = evt[4] | (|(wake_en_reg & evt[3:0] & {3'b111, cmp_ok}));
  // refuse entry while any flag set
  assign enter_low = wr_wcfg & (wake_flags_reg == 5'h00) &
                     (wdata[BIT_SLEEP] | wdata[BIT_SUSPEND]);

  always_comb begin
    mode_next = mode_reg;
    if (any_reset) begin
      mode_next = MODE_RUN;
    end else begin
      unique case (mode_reg)
        MODE_RUN: begin
          if (wr_cpu & wdata[BIT_STOP]) begin
            mode_next = MODE_STOP;
          // sleep bit 7 wins over suspend bit 6
          end else if (enter_low) begin
            mode_next = wdata[BIT_SLEEP] ? MODE_SLEEP : MODE_SUSPEND;
          end
        end
        MODE_STOP: mode_next = MODE_STOP;
        MODE_SUSPEND, MODE_SLEEP: begin
          if (wake_now) begin
            mode_next = MODE_RUN;
          end
        end
      endcase
    end
  end

  // mode register; sleep entry or exit also switches the power outputs, and entry clears the pin timer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_reg <= MODE_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ----------------------------------------------------------------
  // wake flags
  // ----------------------------------------------------------------
  // hardware set wins over the clear bit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wake_flags_reg <= WAKE_FLAGS_RST;
    end else if (wr_wcfg & wdata[BIT_CLEAR]) begin
      wake_flags_reg <= evt;
    end else begin
      wake_flags_reg <= wake_flags_reg | evt;
    end
  end

  // flags hidden two clocks after suspend wake
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mask_cnt_reg <= 2'h0;
    end else if (mode_reg == MODE_SUSPEND && mode_next == MODE_RUN) begin
      mask_cnt_reg <= FLAG_MASK_CYC;
    end else if (mask_cnt_reg != 2'h0) begin
      mask_cnt_reg <= mask_cnt_reg - 2'h1;
    end
  end

  assign flags_visible = (mask_cnt_reg != 2'h0) ? 5'h00 : wake_flags_reg;

  // ----------------------------------------------------------------
  // pin reset timer
  // ----------------------------------------------------------------
  // counts awake time after a pin edge
  always_ff @(posedge clk) begin
    if (!rstn || any_reset) begin
      pin_armed_reg <= 1'b0;
      pin_cnt_reg <= 8'h00;
    end else if (evt[4]) begin
      pin_armed_reg <= 1'b1;
      pin_cnt_reg <= 8'h00;
    end else if (mode_next == MODE_SUSPEND || mode_next == MODE_SLEEP) begin
      pin_armed_reg <= 1'b0;
      pin_cnt_reg <= 8'h00;
    end else if (pin_armed_reg) begin
      pin_cnt_reg <= pin_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // software configuration
  // ----------------------------------------------------------------
  // a reset with the monitor off is a power-on reset of all software configuration
  always_ff @(posedge clk) begin
    if (!rstn || (any_reset && mon_off_reg)) begin
      gp_flags_reg <= GP_FLAGS_RST;
      wake_en_reg <= WAKE_EN_RST;
      rtc_oe_reg <= 1'b0;
      wake_oe_reg <= 1'b0;
      mon_off_reg <= 1'b0;
      rail_float_reg <= 1'b0;
      lcd_en_reg <= 1'b0;
    end else begin
      if (wr_cpu) begin
        gp_flags_reg <= wdata[7:2];
      end
      // enables taken in the same write as the mode select
      if (wr_wcfg) begin
        wake_en_reg <= wdata[3:0];
      end
      if (wr_mode) begin
        rtc_oe_reg <= wdata[BIT_RTC_OE];
        wake_oe_reg <= wdata[BIT_WAKE_OE];
        mon_off_reg <= wdata[BIT_MON_OFF];
      end
      if (wr_conv) begin
        rail_float_reg <= wdata[BIT_RAIL_FLOAT];
      end
      if (wr_ctrl) begin
        lcd_en_reg <= wdata[BIT_LCD_EN];
      end
    end
  end

  // ----------------------------------------------------------------
  // power outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      core_reset <= 1'b0;
      power_on_reset <= 1'b0;
      restart_address <= RESET_VECTOR;
    end else begin
      // reset restarts at the reset vector
      core_reset <= any_reset;
      power_on_reset <= any_reset & mon_off_reg;
      restart_address <= RESET_VECTOR;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cpu_halt <= 1'b0;
      precision_osc_en <= 1'b1;
      low_power_osc_en <= 1'b1;
      sys_clk_en <= 1'b1;
      core_regulator_en <= 1'b1;
      ram_on_battery <= 1'b0;
      rail_to_battery <= 1'b0;
      rail_floating <= 1'b0;
      gpio_hold <= 1'b0;
      port_match_live <= 1'b1;
      battery_monitor_en <= 1'b1;
      wake_request_out <= 1'b1;
      wake_request_oe_n <= 1'b1;
    end else begin
      // stop halts cpu and precision oscillator only
      cpu_halt <= mode_next != MODE_RUN;
      precision_osc_en <= mode_next == MODE_RUN;
      // suspend stops all oscillators and the clock
      low_power_osc_en <= mode_next != MODE_SUSPEND && mode_next != MODE_SLEEP;
      sys_clk_en <= mode_next == MODE_RUN || mode_next == MODE_STOP;
      // sleep removes core power, RAM moves to battery
      core_regulator_en <= mode_next != MODE_SLEEP;
      ram_on_battery <= mode_next == MODE_SLEEP;
      // analog rail to battery or floating in sleep
      rail_to_battery <= mode_next == MODE_SLEEP && !rail_float_reg;
      rail_floating <= mode_next == MODE_SLEEP && rail_float_reg;
      gpio_hold <= mode_next == MODE_SLEEP;
      // port match stays live in every mode
      port_match_live <= 1'b1;
      battery_monitor_en <= !(mon_off_reg && !(any_reset));
      wake_request_out <= mode_next != MODE_SLEEP;
      // pin driven only with its enable set
      wake_request_oe_n <= !(wr_mode ? wdata[BIT_WAKE_OE] : wake_oe_reg);
    end
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_rdy_reg <= 1'b0;
      w_rdy_reg <= 1'b0;
      b_vld_reg <= 1'b0;
      b_resp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      aw_rdy_reg <= 1'b0;
      w_rdy_reg <= 1'b0;
      b_vld_reg <= 1'b1;
      b_resp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else begin
      aw_rdy_reg <= awvalid & wvalid & ~b_vld_reg;
      w_rdy_reg <= awvalid & wvalid & ~b_vld_reg;
      if (b_vld_reg && bready) begin
        b_vld_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ar_rdy_reg <= 1'b0;
      r_vld_reg <= 1'b0;
      r_resp_reg <= RESP_OKAY;
      r_data_reg <= 32'h0000_0000;
    end else if (ar_rdy_reg && arvalid) begin
      ar_rdy_reg <= 1'b0;
      r_vld_reg <= 1'b1;
      r_resp_reg <= RESP_OKAY;
      unique case (araddr)
        OFF_CPU_POWER: r_data_reg <= {24'h0, gp_flags_reg, 2'b00};
        OFF_WAKE_CFG: r_data_reg <= {27'h0, flags_visible};
        OFF_UNIT_MODE: r_data_reg <= {24'h0, rtc_oe_reg, wake_oe_reg, mon_off_reg, 5'h00};
        OFF_CONVERTER: r_data_reg <= {30'h0, rail_float_reg, 1'b0};
        OFF_CONTROL: r_data_reg <= {26'h0, mode_reg, 3'b000, lcd_en_reg};
        default: begin
          r_data_reg <= 32'h0000_0000;
          r_resp_reg <= RESP_SLVERR;
        end
      endcase
    end else begin
      ar_rdy_reg <= arvalid & ~r_vld_reg & ~ar_rdy_reg;
      if (r_vld_reg && rready) begin
        r_vld_reg <= 1'b0;
      end
    end
  end

  assign awready = aw_rdy_reg;
  assign wready = w_rdy_reg;
  assign bvalid = b_vld_reg;
  assign bresp = b_resp_reg;
  assign arready = ar_rdy_reg;
  assign rvalid = r_vld_reg;
  assign rresp = r_resp_reg;
  assign rdata = r_data_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  stop_entry_a: assert property (@(posedge clk) disable iff (!rstn)
    mode_reg == MODE_RUN && wr_cpu && wdata[BIT_STOP] && !any_reset
    |=> mode_reg == MODE_STOP && cpu_halt && !precision_osc_en && low_power_osc_en)
    else $error("stop entry wrong");

  stop_exit_a: assert property (@(posedge clk) disable iff (!rstn)
    mode_reg == MODE_STOP && !any_reset |=> mode_reg == MODE_STOP)
    else $error("stop left without reset");

  lost_clock_a: assert property (@(posedge clk) disable iff (!rstn)
    lcd_en_reg && clock_missing |=> core_reset && mode_reg == MODE_RUN)
    else $error("lost clock reset missing");

  suspend_clk_a: assert property (@(posedge clk) disable iff (!rstn)
    mode_reg == MODE_SUSPEND |-> !sys_clk_en && !low_power_osc_en)
    else $error("suspend clocks running");

  flag_mask_a: assert property (@(posedge clk) disable iff (!rstn)
    mode_reg == MODE_SUSPEND && wake_now && !any_reset
    |=> (flags_visible == 5'h00)[*2] ##1 flags_visible == wake_flags_reg)
    else $error("flag mask length wrong");

  pin_wake_a: assert property (@(posedge clk) disable iff (!rstn)
    (mode_reg == MODE_SUSPEND || mode_reg == MODE_SLEEP) && evt[4]
    |=> mode_reg == MODE_RUN ##0 wake_flags_reg[4])
    else $error("pin edge did not wake");

  sleep_power_a: assert property (@(posedge clk) disable iff (!rstn)
    mode_reg == MODE_SLEEP |-> !core_regulator_en && ram_on_battery && gpio_hold)
    else $error("sleep power state wrong");

  wake_req_a: assert property (@(posedge clk) disable iff (!rstn)
    wake_request_out == (mode_reg != MODE_SLEEP))
    else $error("wake request level wrong");

  rail_a: assert property (@(posedge clk) disable iff (!rstn)
    mode_reg == MODE_SLEEP |-> rail_floating == rail_float_reg && rail_to_battery != rail_float_reg)
    else $error("analog rail wrong in sleep");

  cmp_sleep_a: assert property (@(posedge clk) disable iff (!rstn)
    mode_reg == MODE_SLEEP && !two_cell_mode && evt == 5'h01 && !any_reset
    |=> mode_reg == MODE_SLEEP)
    else $error("comparator woke one-cell sleep");

  por_a: assert property (@(posedge clk) disable iff (!rstn)
    any_reset && mon_off_reg |=> power_on_reset && !mon_off_reg && battery_monitor_en)
    else $error("power-on reset missing");

  pin_reset_a: assert property (@(posedge clk) disable iff (!rstn)
    pin_reset_fire |-> $past(pin_cnt_reg) == 8'(PIN_WAKE_CYC))
    else $error("pin reset timing wrong");

  refuse_a: assert property (@(posedge clk) disable iff (!rstn)
    mode_reg == MODE_RUN && wake_flags_reg != 5'h00 |=> mode_reg != MODE_SLEEP
    && mode_reg != MODE_SUSPEND)
    else $error("entry with flag set");

endmodule

// ---- sim/wake_listener.sv ----
/*
  Model of an external device woken by the wake request pin.
  Assumes the bench resolves the pin, which is pulled low when not driven.
*/
`timescale 1ns/1ns
module wake_listener (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wake_pin,
  output logic dev_awake
);
  // ----------------------------
  // wake follows the request pin
  // ----------------------------
  // asleep while low
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dev_awake <= 1'h0;
    end else begin
      dev_awake <= wake_pin;
    end
  end
endmodule

// ---- sim/low_power_mode_controller_bench.sv ----
/*
  Self-checking bench for the low-power mode controller.
  Assumes the design package and the wake listener model.
*/
`timescale 1ns/1ns
module low_power_mode_controller_bench;
  import power_unit_pkg::*;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, pin_n, two_cell;
  logic awready, wready, bvalid, arready, rvalid, core_reset, por, halt, posc, lposc;
  logic sclk, creg, ram_bat, rail_bat, rail_flt, hold, pm_live, mon_en, wreq, oe_n, dev_awake;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0] wstrb;
  logic [5:0] ins;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] restart;
  int err_count = 0, check_count = 0, cyc = 0, rst_seen = 0, por_seen = 0;
  // ------------------
  // design and partner
  // ------------------
  low_power_mode_controller low_power_mode_controller_i (.clk(clk), .rstn(rstn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .osc_fail(ins[3]), .clock_alarm(ins[2]),
    .port_match(ins[1]), .comparator_out(ins[0]), .reset_pin_n(pin_n),
    .clock_missing(ins[4]), .internal_reset(ins[5]), .two_cell_mode(two_cell),
    .core_reset(core_reset), .power_on_reset(por), .restart_address(restart),
    .cpu_halt(halt), .precision_osc_en(posc), .low_power_osc_en(lposc), .sys_clk_en(sclk),
    .core_regulator_en(creg), .ram_on_battery(ram_bat), .rail_to_battery(rail_bat),
    .rail_floating(rail_flt), .gpio_hold(hold), .port_match_live(pm_live),
    .battery_monitor_en(mon_en), .wake_request_out(wreq), .wake_request_oe_n(oe_n));
  wake_listener wake_listener_i (.clk(clk), .rstn(rstn), .wake_pin(oe_n ? 1'h0 : wreq),
    .dev_awake(dev_awake));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (core_reset === 1'h1) rst_seen <= rst_seen + 1;
    if (por === 1'h1) por_seen <= por_seen + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  // -----
  // tasks
  // -----
  task automatic stop_test();
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rd_val = rdata;
    resp = rresp;
    rready <= 1'h0;
    #1;
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    ins[b] <= 1'h1;
    @(posedge clk);
    @(posedge clk);
    ins[b] <= 1'h0;
    #1;
  endtask
  // ---------
  // scenarios
  // ---------
  task automatic s_stop();
    int n;
    wr(OFF_CPU_POWER, 32'h02);
    chk({halt, posc, lposc}, 32'h5);
    n = rst_seen;
    pulse(5);
    chk({halt, rst_seen > n}, 32'h1);
    chk(restart, 32'h0);
    wr(OFF_CONTROL, 32'h01);
    wr(OFF_CPU_POWER, 32'h02);
    pulse(4);
    chk(halt, 32'h0);
    wr(OFF_CONTROL, 32'h00);
    rd(OFF_CONTROL);
    chk(rd_val, 32'h0);
  endtask
  task automatic s_suspend();
    for (int b = 0; b < 4; b++) begin
      wr(OFF_WAKE_CFG, 32'h40 | (32'h1 << b));
      chk({sclk, lposc, halt}, 32'h1);
      pulse(b);
      chk(sclk, 32'h1);
      rd(OFF_WAKE_CFG);
      chk(rd_val[b], 32'h1);
      wr(OFF_WAKE_CFG, 32'h40 | (32'h1 << b));
      chk(sclk, 32'h1);
      wr(OFF_WAKE_CFG, 32'h20);
    end
  endtask
  task automatic s_sleep();
    wr(OFF_CPU_POWER, 32'hFC);
    wr(OFF_UNIT_MODE, 32'h40);
    chk({oe_n, dev_awake}, 32'h1);
    wr(OFF_WAKE_CFG, 32'hC5);
    chk({creg, ram_bat, hold, pm_live}, 32'h7);
    chk({wreq, dev_awake, rail_bat, rail_flt}, 32'h2);
    pulse(0);
    chk(wreq, 32'h0);
    pulse(2);
    chk({wreq, dev_awake, creg}, 32'h7);
    rd(OFF_CPU_POWER);
    chk(rd_val, 32'hFC);
    wr(OFF_WAKE_CFG, 32'h20);
    @(posedge clk);
    two_cell <= 1'h1;
    wr(OFF_WAKE_CFG, 32'h81);
    // four idle cycles after sleep write
    repeat (4) @(posedge clk);
    pulse(0);
    chk(wreq, 32'h1);
    wr(OFF_WAKE_CFG, 32'h20);
    wr(OFF_WAKE_CFG, 32'h82);
    chk(wreq, 32'h0);
    pulse(1);
    chk(wreq, 32'h1);
    wr(OFF_WAKE_CFG, 32'h20);
  endtask
  task automatic s_pin();
    int n;
    wr(OFF_CONVERTER, 32'h02);
    wr(OFF_WAKE_CFG, 32'h84);
    chk({rail_flt, rail_bat}, 32'h2);
    n = rst_seen;
    @(posedge clk);
    pin_n <= 1'h0;
    @(posedge clk);
    @(posedge clk);
    pin_n <= 1'h1;
    #1;
    chk(wreq, 32'h1);
    repeat (100) @(posedge clk);
    chk(rst_seen, n);
    repeat (60) @(posedge clk);
    chk(rst_seen > n, 32'h1);
    rd(OFF_WAKE_CFG);
    chk(rd_val[4], 32'h1);
    wr(OFF_WAKE_CFG, 32'h20);
  endtask
  task automatic s_monitor();
    int n;
    wr(OFF_UNIT_MODE, 32'h60);
    chk({mon_en, oe_n}, 32'h0);
    n = por_seen;
    pulse(5);
    chk({mon_en, por_seen > n}, 32'h3);
    rd(OFF_CPU_POWER);
    chk(rd_val, 32'h0);
    wr(8'h20, 32'hFF);
    chk(resp, RESP_SLVERR);
    rd(8'h20);
    chk(resp, RESP_SLVERR);
    chk(rd_val, 32'h0);
  endtask
  initial begin
    rstn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready, two_cell} = '0;
    {awaddr, araddr, wdata, ins} = '0;
    wstrb = 4'h1;
    pin_n = 1'h1;
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    #1;
    chk({wreq, oe_n, mon_en, halt}, 32'hE);
    s_stop();
    s_suspend();
    s_sleep();
    s_pin();
    s_monitor();
    stop_test();
  end
endmodule
